// ---- logic/amr_map.svh ----
/*
 * Register indices, field positions, reset values and sizes of the
 * converter mute and ramp control block.
 * Assumes an AXI4-Lite word bus where a byte address is four times an index.
 */
`ifndef AMR_MAP_SVH
`define AMR_MAP_SVH

// ==========================================================
// Register map
`define AMR_ADDR_W 18
`define AMR_MUTE_CTRL_INDEX 16'hF581
`define AMR_STATUS_INDEX 16'hF582
`define AMR_MUTE_CTRL_RESET 16'h0000
`define AMR_RESP_OKAY 2'h0
`define AMR_RESP_SLVERR 2'h2

// ==========================================================
// Fields of the mute control register
`define AMR_MANUAL_LSB 0
`define AMR_BLOCK0_RAMP_BIT 8
`define AMR_BLOCK1_RAMP_BIT 9
`define AMR_LOCK_MUTE_BIT 10
`define AMR_PAIRS_PER_BLOCK 4

// ==========================================================
// Fields of the status register
`define AMR_STAT_UNLOCKED_LSB 0
`define AMR_STAT_RAMPING_LSB 8
`define AMR_STAT_MUTED_LSB 16

// ==========================================================
// Datapath and ramp sizes
`define AMR_PAIRS 8
`define AMR_PAIR_W 3
`define AMR_SAMPLE_W 24
`define AMR_GAIN_W 12
`define AMR_RAMP_SAMPLES 12'h800
`define AMR_RAMP_SHIFT 11
`define AMR_FIFO_DEPTH 8

`endif

// ---- logic/amr_pkg.sv ----
/*
 * Types shared by the converter mute and ramp control block.
 * Assumes amr_map.svh is on the include path.
 */
`include "amr_map.svh"

package amr_pkg;

    // ==========================================================
    // Stereo sample carried through the gain path
    typedef struct packed {
        logic [`AMR_PAIR_W-1:0] pair;
        logic signed [`AMR_SAMPLE_W-1:0] left;
        logic signed [`AMR_SAMPLE_W-1:0] right;
    } amr_sample_t;

    // ==========================================================
    // Layout of the mute control register, most significant first
    typedef struct packed {
        logic [4:0] reserved;
        logic muteOnLockLoss;
        logic block1RampDisable;
        logic block0RampDisable;
        logic [7:0] pairManualMute;
    } amr_ctrl_t;

    typedef logic [`AMR_GAIN_W-1:0] amr_gain_t;

endpackage

// ---- logic/amr_fifo.sv ----
/*
 * Small synchronous FIFO with valid and ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps

module amr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr_reg;
    logic [PW-1:0] rdPtr_reg;
    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic push;
    logic pop;

    function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
        if (p == PW'(DEPTH - 1))
            return '0;
        return PW'(p + 1'b1);
    endfunction

    // ==========================================================
    // Handshakes
    assign push = inValid & inReady;
    assign pop = outValid & outReady;
    assign outValid = (count_reg != '0);
    assign outData = mem[rdPtr_reg];

    always_comb
    begin
        count_next = count_reg;
        if (push & ~pop)
            count_next = CW'(count_reg + 1'b1);
        else if (pop & ~push)
            count_next = CW'(count_reg - 1'b1);
    end

    // ==========================================================
    // Storage and pointers
    always_ff @(posedge core_clk)
    begin
        if (push)
            mem[wrPtr_reg] <= inData;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
            inReady <= 1'b0;
        end
        else
        begin
            if (push)
                wrPtr_reg <= nextPtr(wrPtr_reg);
            if (pop)
                rdPtr_reg <= nextPtr(rdPtr_reg);
            count_reg <= count_next;
            // Registered ready keeps the input free of a path from the sink.
            inReady <= (count_next != CW'(DEPTH));
        end
    end

endmodule

// ---- logic/amr_gain_ramp.sv ----
/*
 * Per-pair linear gain ramp between zero and full scale.
 * Assumes one strobe per input sample of the pair, on the same clock.
 */
`timescale 1ns/1ps

module amr_gain_ramp
    import amr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sampleStrobe,
    input wire logic muteTarget,
    input wire logic bypass,
    output amr_gain_t gain_reg
);

    // ==========================================================
    // Gain counter
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            gain_reg <= `AMR_RAMP_SAMPLES;
        else if (bypass)
            gain_reg <= `AMR_RAMP_SAMPLES;
        else if (sampleStrobe)
        begin
            if (muteTarget && gain_reg != '0)
                gain_reg <= amr_gain_t'(gain_reg - 1'b1);
            else if (!muteTarget && gain_reg != `AMR_RAMP_SAMPLES)
                gain_reg <= amr_gain_t'(gain_reg + 1'b1);
        end
    end

endmodule

// ---- logic/amr_mute_ramp.sv ----
/*
 * Mute and ramp control for eight stereo converter pairs in two blocks,
 * with an AXI4-Lite register slave and a buffered gain datapath.
 * Assumes lock conditions and samples come from logic on core_clk.
 */
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps

// Behaviour
// - Bit n of the low control byte mutes pair n when set.
// - Bits 8 and 9 disable ramped muting for pairs 0 to 3 and 4 to 7.
// - Gain moves linearly during both ramp-down and ramp-up.
// - A full ramp between zero and full scale takes exactly 2048 input samples of its pair.
// - With lock-loss muting on, a pair that loses lock mutes if its block is enabled.
// - A lock-loss mute always ramps and never steps the gain.
// - A pair that regains lock ramps back up unless manually muted or disabled.
// - A manual mute keeps a pair muted regardless of lock state.
// - Block 1 disabled ignores mutes of pairs 7 to 4 and keeps them active.
// - Block 0 disabled ignores mutes of pairs 3 to 0 and keeps them active.
// - With lock-loss muting off, losing lock causes no mute.
// - A pair is locked only with target rate set, input steady and ratio known.
module amr_mute_ramp
    import amr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [`AMR_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`AMR_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [`AMR_PAIRS-1:0] targetRateSet,
    input wire logic [`AMR_PAIRS-1:0] inputRateSteady,
    input wire logic [`AMR_PAIRS-1:0] ratioCalculated,
    input wire amr_sample_t inSample,
    input wire logic inValid,
    output logic inReady,
    output amr_sample_t outSample_reg,
    output logic outValid_reg,
    input wire logic outReady
);

    // ==========================================================
    // Declarations
    amr_ctrl_t ctrl_reg;
    logic awHeld_reg;
    logic wHeld_reg;
    logic [`AMR_ADDR_W-1:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic doWrite;
    logic [`AMR_PAIRS-1:0] locked;
    logic [`AMR_PAIRS-1:0] muteTarget;
    logic [`AMR_PAIRS-1:0] bypass;
    logic [`AMR_PAIRS-1:0] sampleStrobe;
    logic [`AMR_PAIRS-1:0] ramping;
    logic [`AMR_PAIRS-1:0] silent;
    amr_gain_t gain [`AMR_PAIRS];
    amr_sample_t fifoData;
    logic fifoValid;
    logic fifoPop;
    logic [31:0] statusWord;

    // ==========================================================
    // Helpers
    function automatic logic regHit(
        input logic [`AMR_ADDR_W-1:0] addr,
        input logic [15:0] index
    );
        return addr == {index, 2'b00};
    endfunction

    // The gain gets a zero sign bit so the signed product treats it as positive.
    function automatic logic signed [`AMR_SAMPLE_W-1:0] applyGain(
        input logic signed [`AMR_SAMPLE_W-1:0] s,
        input amr_gain_t g
    );
        logic signed [`AMR_SAMPLE_W+`AMR_GAIN_W:0] prod;
        prod = s * $signed({1'b0, g});
        return prod[`AMR_SAMPLE_W+`AMR_RAMP_SHIFT-1:`AMR_RAMP_SHIFT];
    endfunction

    // ==========================================================
    // Write address and data capture, either order
    // Taking no new write while a response waits keeps one write in flight.
    assign doWrite = awHeld_reg & wHeld_reg & ~s_axi_bvalid;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            awHeld_reg <= 1'b0;
            awAddr_reg <= '0;
            s_axi_awready <= 1'b1;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        else if (doWrite)
            awHeld_reg <= 1'b0;
        else if (s_axi_bvalid && s_axi_bready)
            s_axi_awready <= 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            wHeld_reg <= 1'b0;
            wData_reg <= '0;
            wStrb_reg <= '0;
            s_axi_wready <= 1'b1;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        else if (doWrite)
            wHeld_reg <= 1'b0;
        else if (s_axi_bvalid && s_axi_bready)
            s_axi_wready <= 1'b1;
    end

    // ==========================================================
    // Write response
    // Unmapped writes get an error but still complete the handshake.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AMR_RESP_OKAY;
        end
        else if (doWrite)
        begin
            s_axi_bvalid <= 1'b1;
            // The status word is read-only; writes to it are accepted and dropped.
            if (regHit(awAddr_reg, `AMR_MUTE_CTRL_INDEX) ||
                regHit(awAddr_reg, `AMR_STATUS_INDEX))
                s_axi_bresp <= `AMR_RESP_OKAY;
            else
                s_axi_bresp <= `AMR_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // ==========================================================
    // Mute control register
    // Reserved bits are stored as written so software reads back what it wrote.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            ctrl_reg <= `AMR_MUTE_CTRL_RESET;
        else if (doWrite && regHit(awAddr_reg, `AMR_MUTE_CTRL_INDEX))
        begin
            if (wStrb_reg[0])
                ctrl_reg[7:0] <= wData_reg[7:0];
            if (wStrb_reg[1])
                ctrl_reg[15:8] <= wData_reg[15:8];
        end
    end

    // ==========================================================
    // Read channel, answered one cycle after the address is taken
    // Status is sampled at the address edge; a later change shows on the next read.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `AMR_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `AMR_RESP_OKAY;
            if (regHit(s_axi_araddr, `AMR_MUTE_CTRL_INDEX))
                s_axi_rdata <= {16'h0000, ctrl_reg};
            else if (regHit(s_axi_araddr, `AMR_STATUS_INDEX))
                s_axi_rdata <= statusWord;
            else
            begin
                s_axi_rdata <= '0;
                s_axi_rresp <= `AMR_RESP_SLVERR;
            end
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ==========================================================
    // Mute targets per pair
    // Lock inputs come from logic on this clock, so they need no synchroniser.
    // three lock conditions
    assign locked = targetRateSet & inputRateSteady & ratioCalculated;

    always_comb
    begin
        for (int p = 0; p < `AMR_PAIRS; p++)
        begin
            bypass[p] = (p < `AMR_PAIRS_PER_BLOCK) ? ctrl_reg.block0RampDisable
                                                   : ctrl_reg.block1RampDisable;
            muteTarget[p] = ctrl_reg.pairManualMute[p] |
                            (ctrl_reg.muteOnLockLoss & ~locked[p]);
            // one strobe per accepted input sample
            sampleStrobe[p] = inValid & inReady & (inSample.pair == `AMR_PAIR_W'(p));
            // Ramping and silence feed the status word only.
            ramping[p] = ~bypass[p] & (muteTarget[p] ? (gain[p] != '0)
                                      : (gain[p] != `AMR_RAMP_SAMPLES));
            silent[p] = (gain[p] == '0);
        end
    end

    assign statusWord = {8'h00, silent, ramping, ~locked};

    // ==========================================================
    // Ramp units
    // Each pair owns its counter, so ramps of different pairs never interact.
    for (genvar p = 0; p < `AMR_PAIRS; p++)
    begin : g_ramp
        amr_gain_ramp u_ramp (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .sampleStrobe(sampleStrobe[p]),
            .muteTarget(muteTarget[p]),
            .bypass(bypass[p]),
            .gain_reg(gain[p])
        );
    end

    // ==========================================================
    // Sample buffer
    // The ramp counts samples as they enter, so gain leads the audio by
    // at most the buffer depth; at 2048 steps per ramp that is inaudible.
    amr_fifo #(
        .WIDTH($bits(amr_sample_t)),
        .DEPTH(`AMR_FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .inData(inSample),
        .inValid(inValid),
        .inReady(inReady),
        .outData(fifoData),
        .outValid(fifoValid),
        .outReady(fifoPop)
    );

    assign fifoPop = fifoValid & (~outValid_reg | outReady);

    // ==========================================================
    // Gain stage and output register
    // The register refills in the cycle it is taken, so the stream keeps full rate.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            outValid_reg <= 1'b0;
            outSample_reg <= '0;
        end
        else if (fifoPop)
        begin
            outValid_reg <= 1'b1;
            outSample_reg.pair <= fifoData.pair;
            outSample_reg.left <= applyGain(fifoData.left, gain[fifoData.pair]);
            outSample_reg.right <= applyGain(fifoData.right, gain[fifoData.pair]);
        end
        else if (outReady)
            outValid_reg <= 1'b0;
    end

endmodule

// ---- verif/amr_mute_ramp_monitor.sv ----
/*
 * Concurrent checks on the ports of the mute and ramp control block.
 * Assumes amr_map.svh on the include path and the bind at the foot.
 */
`timescale 1ns/1ps
`include "amr_map.svh"

module amr_mute_ramp_monitor
    import amr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`AMR_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire amr_sample_t outSample_reg,
    input wire logic outValid_reg,
    input wire logic outReady
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // Bus handshakes
    sequence rdOther;
        s_axi_arvalid && s_axi_arready && s_axi_araddr != {`AMR_MUTE_CTRL_INDEX, 2'h0}
            && s_axi_araddr != {`AMR_STATUS_INDEX, 2'h0};
    endsequence
    sequence bTaken;
        s_axi_bvalid && s_axi_bready;
    endsequence

    a_bresp_stable: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response changed before it was taken.");
    a_rdata_stable: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data changed before it was taken.");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("Read answer late.");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> ##1 s_axi_bvalid) else $error("Write answer late.");
    a_unmapped_read: assert property (rdOther |=> s_axi_rresp == `AMR_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("Unmapped read not refused.");
    a_write_reopen: assert property (bTaken |=> ##1 s_axi_awready && s_axi_wready)
        else $error("Write channels did not reopen.");
    a_write_closed: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("Write accepted while a response is pending.");

    // ==========================================================
    // Sample output
    a_out_stable: assert property (outValid_reg && !outReady |=> outValid_reg && $stable(outSample_reg))
        else $error("Output sample changed before it was taken.");
endmodule

bind amr_mute_ramp amr_mute_ramp_monitor amr_mute_ramp_monitor_inst (
    .core_clk(core_clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .outSample_reg(outSample_reg), .outValid_reg(outValid_reg),
    .outReady(outReady)
);

// ---- verif/amr_mute_ramp_tb.sv ----
/*
 * Self-checking bench: register access, FIFO fill and drain, mute ramps.
 * Assumes the design and the monitor are compiled before it.
 */
`timescale 1ns/1ps
`include "amr_map.svh"

module amr_mute_ramp_tb
    import amr_pkg::*;
;
    localparam logic [17:0] CTRL = {`AMR_MUTE_CTRL_INDEX, 2'h0};
    localparam logic [17:0] STAT = {`AMR_STATUS_INDEX, 2'h0};
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [17:0] awA = 18'h0;
    logic [17:0] arA = 18'h0;
    logic [31:0] wD = 32'h0;
    logic [31:0] rD;
    logic [1:0] bResp;
    logic [1:0] rResp;
    logic awV = 1'b0, awR, wV = 1'b0, wR, bV, bR = 1'b0, arV = 1'b0, arR, rV, rR = 1'b0;
    logic [7:0] trs = 8'hFF;
    logic [7:0] rc = 8'hFF;
    amr_sample_t inS = '0;
    amr_sample_t outS;
    logic inV = 1'b0, inR, outV, outR = 1'b1;
    int bad_count = 0;
    int comparisons = 0;
    // Cycles that the bench keeps bready or rready low, to stall a response.
    int readyHold = 0;

    amr_mute_ramp amr_mute_ramp_inst (
        .core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awA), .s_axi_awvalid(awV),
        .s_axi_awready(awR), .s_axi_wdata(wD), .s_axi_wstrb(4'hF), .s_axi_wvalid(wV),
        .s_axi_wready(wR), .s_axi_bresp(bResp), .s_axi_bvalid(bV), .s_axi_bready(bR),
        .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arR), .s_axi_rdata(rD),
        .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(rR), .targetRateSet(trs),
        .inputRateSteady(8'hFF), .ratioCalculated(rc), .inSample(inS), .inValid(inV),
        .inReady(inR), .outSample_reg(outS), .outValid_reg(outV), .outReady(outR)
    );

    initial
    begin
        forever #50 core_clk = ~core_clk;
    end

    // ==========================================================
    // Checking and bus tasks
    task report_and_stop;
        if (bad_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // A wait that runs out ends the run; the design is taken to be hung.
    task waited(input logic done);
        if (!done)
        begin
            bad_count++;
            $display("Error %0t: handshake timed out", $time);
            report_and_stop();
        end
    endtask

    task axiWrite(input logic [17:0] a, input logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge core_clk);
        awA <= a;
        wD <= d;
        awV <= 1'b1;
        wV <= 1'b1;
        bR <= (readyHold == 0);
        for (int n = 0; n < 200 && !done; n++)
        begin
            @(posedge core_clk);
            if (awV && awR)
                awV <= 1'b0;
            if (wV && wR)
                wV <= 1'b0;
            if (bV && bR)
            begin
                r = bResp;
                bR <= 1'b0;
                done = 1'b1;
            end
            else if (n >= readyHold)
                bR <= 1'b1;
        end
        waited(done);
    endtask

    task axiRead(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge core_clk);
        arA <= a;
        arV <= 1'b1;
        rR <= (readyHold == 0);
        for (int n = 0; n < 200 && !done; n++)
        begin
            @(posedge core_clk);
            if (arV && arR)
                arV <= 1'b0;
            if (rV && rR)
            begin
                d = rD;
                r = rResp;
                rR <= 1'b0;
                done = 1'b1;
            end
            else if (n >= readyHold)
                rR <= 1'b1;
        end
        waited(done);
    endtask

    task statBit(input int b, input logic v);
        logic [31:0] d;
        logic [1:0] r;
        axiRead(STAT, d, r);
        check({31'h0, d[b]}, {31'h0, v});
    endtask

    // One sample of value 0x800 per call, so the output equals the gain.
    task send(input logic [2:0] p, output logic [23:0] g);
        logic done;
        done = 1'b0;
        @(posedge core_clk);
        inS <= {p, 24'h000800, 24'h000800};
        inV <= 1'b1;
        for (int n = 0; n < 200 && !done; n++)
        begin
            @(posedge core_clk);
            if (inV && inR)
                inV <= 1'b0;
            if (outV)
            begin
                g = outS.left;
                done = 1'b1;
            end
        end
        waited(done);
    endtask

    // Gain may be applied before or after its own step, so one step of slack.
    task ramp(input logic [2:0] p, input int n, input int s, input int d);
        logic [23:0] g;
        int e;
        for (int k = 1; k <= n; k++)
        begin
            send(p, g);
            e = s + d * k;
            check({31'h0, g === 24'(e) || g === 24'(e - d)}, 32'h1);
        end
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        logic [23:0] g;
        int n;
        int k;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        axiRead(CTRL, d, r);
        check(d, 32'h0);
        axiWrite(CTRL, 32'hABCDF800, r);
        axiRead(CTRL, d, r);
        check(d, 32'h0000F800);
        readyHold = 3;
        axiWrite(CTRL, 32'h0, r);
        check({30'h0, r}, {30'h0, `AMR_RESP_OKAY});
        axiRead(CTRL, d, r);
        check(d, 32'h0);
        readyHold = 0;
        axiWrite(STAT, 32'hFFFFFFFF, r);
        check({30'h0, r}, {30'h0, `AMR_RESP_OKAY});
        axiRead(18'h3D60C, d, r);
        check({30'h0, r}, {30'h0, `AMR_RESP_SLVERR});
        check(d, 32'h0);
        axiWrite(18'h3D60C, 32'h1, r);
        check({30'h0, r}, {30'h0, `AMR_RESP_SLVERR});
        @(posedge core_clk);
        outR <= 1'b0;
        inS <= {3'h1, 24'h0, 24'h0};
        inV <= 1'b1;
        n = 0;
        repeat (12)
        begin
            @(posedge core_clk);
            if (inR)
            begin
                n++;
                inS <= {3'h1, 24'(n), 24'(n)};
            end
        end
        inV <= 1'b0;
        outR <= 1'b1;
        check({31'h0, n >= 8 && n <= 9}, 32'h1);
        k = 0;
        for (int c = 0; c < 60 && k < n; c++)
        begin
            @(posedge core_clk);
            if (outV)
            begin
                check({8'h0, outS.left}, 32'(k));
                check({8'h0, outS.right}, 32'(k));
                check({29'h0, outS.pair}, 32'h1);
                k++;
            end
        end
        check(32'(k), 32'(n));
        axiWrite(CTRL, 32'h1, r);
        ramp(0, 2047, 2048, -1);
        statBit(16, 1'b0);
        ramp(0, 1, 1, -1);
        statBit(16, 1'b1);
        ramp(1, 1, 2048, 0);
        axiWrite(CTRL, 32'h0, r);
        ramp(0, 1000, 0, 1);
        axiWrite(CTRL, 32'h1, r);
        ramp(0, 999, 1000, -1);
        statBit(16, 1'b0);
        ramp(0, 1, 1, -1);
        statBit(16, 1'b1);
        axiWrite(CTRL, 32'h11, r);
        ramp(4, 10, 2048, -1);
        axiWrite(CTRL, 32'h311, r);
        send(0, g);
        check({8'h0, g}, 32'h800);
        send(4, g);
        check({8'h0, g}, 32'h800);
        axiWrite(CTRL, 32'h0, r);
        rc <= 8'hFB;
        axiRead(STAT, d, r);
        check({24'h0, d[7:0]}, 32'h04);
        ramp(2, 3, 2048, 0);
        axiWrite(CTRL, 32'h400, r);
        ramp(2, 2048, 2048, -1);
        statBit(18, 1'b1);
        axiWrite(CTRL, 32'h404, r);
        rc <= 8'hFF;
        ramp(2, 4, 0, 0);
        axiWrite(CTRL, 32'h400, r);
        ramp(2, 5, 0, 1);
        statBit(10, 1'b1);
        axiWrite(CTRL, 32'h500, r);
        trs <= 8'hFD;
        ramp(1, 3, 2048, 0);
        report_and_stop();
    end
endmodule
